// ==== inc/titp_cnt_if.sv ====
// Carrier between the register side and one counter channel
`timescale 1ns/10ps
`default_nettype none
interface titp_cnt_if;
    logic cfg_wr;
    logic [2:0] mode;
    logic bcd;
    logic load;
    logic [15:0] load_val;
    logic hold;
    logic [15:0] cnt;
    logic out;
    logic null_cnt;
    modport host (output cfg_wr, output mode, output bcd, output load, output load_val,
        output hold, input cnt, input out, input null_cnt);
    modport core (input cfg_wr, input mode, input bcd, input load, input load_val,
        input hold, output cnt, output out, output null_cnt);
endinterface
`default_nettype wire

// ==== inc/titp_pkg.sv ====
// Shared constants and helpers for the triple interval timer pacer
package titp_pkg;
    localparam int NUM_CNT = 3;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_CNT [NUM_CNT] = '{5'h18, 5'h1a, 5'h1c};
    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h1e;
    localparam int SEL_LO = 6;
    localparam int AF_LO = 4;
    localparam int MODE_LO = 1;
    localparam int BCD_BIT = 0;
    localparam int RB_CNT_N = 5;
    localparam int RB_STA_N = 4;
    localparam int RB_C0 = 1;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] AF_LATCH = 2'h0;
    localparam logic [1:0] AF_LSB = 2'h1;
    localparam logic [1:0] AF_MSB = 2'h2;
    localparam logic [1:0] AF_BOTH = 2'h3;
    localparam logic [2:0] MODE_STOP_TC = 3'h0;
    localparam logic [2:0] MODE_ONESHOT = 3'h1;
    localparam logic [2:0] MODE_RATE = 3'h2;
    localparam logic [2:0] MODE_SQUARE = 3'h3;
    localparam logic [2:0] MODE_SW_STROBE = 3'h4;
    localparam logic [2:0] MODE_HW_STROBE = 3'h5;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_TWO = 16'h0002;
    localparam logic [CNT_W-1:0] BCD_TOP = 16'h9999;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam int CLK_KHZ = 25000;
    localparam int CNT_CLK_KHZ = 10000;
    localparam int ACC_W = 16;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CNT_CLK_KHZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_KHZ);
    // Mode codes 6 and 7 alias the rate and square modes
    function automatic logic [2:0] mode_norm(input logic [2:0] m);
        return m[1] ? {1'b0, m[1:0]} : m;
    endfunction
    // Decrement by one in binary or in four BCD digits
    function automatic logic [CNT_W-1:0] cnt_dec(input logic [CNT_W-1:0] v, input logic bcd);
        logic [CNT_W-1:0] r;
        logic br;
        r = v - CNT_ONE;
        br = 1'b1;
        if (bcd)
        begin
            r = v;
            for (int k = 0; k < 4; k++)
            begin
                if (br)
                begin
                    br = (v[k*4+:4] == 4'h0);
                    r[k*4+:4] = br ? 4'h9 : v[k*4+:4] - 4'h1;
                end
            end
        end
        return r;
    endfunction
endpackage

// ==== rtl/titp_counter.sv ====
// One programmable down-counter channel with its six operating modes
`timescale 1ns/10ps
`default_nettype none
module titp_counter (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic gate,
    input wire logic gate_rise,
    titp_cnt_if.core cif
);
    import titp_pkg::*;
    logic [CNT_W-1:0] cr_reg, ce_reg, dec1, dec2, dec3, sq_nxt;
    logic out_reg, null_reg, run_reg, newc_reg, trig_reg, first_reg, trig;
    logic [2:0] m;
    // Step values, square wave takes odd counts in a 1/3 first step
    assign m = mode_norm(cif.mode);
    assign trig = trig_reg | gate_rise;
    assign dec1 = cnt_dec(ce_reg, cif.bcd);
    assign dec2 = cnt_dec(dec1, cif.bcd);
    assign dec3 = cnt_dec(dec2, cif.bcd);
    assign sq_nxt = (first_reg && cr_reg[0]) ? (out_reg ? dec1 : dec3) : dec2;
    assign cif.cnt = ce_reg;
    assign cif.out = out_reg;
    assign cif.null_cnt = null_reg;
    // Gate rising edge is held until the next count clock
    always_ff @(posedge clk)
    begin
        if (!resetn)
            trig_reg <= 1'b0;
        else if (gate_rise)
            trig_reg <= 1'b1;
        else if (tick)
            trig_reg <= 1'b0;
    end
    // Count element, output level and null-count flag
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cr_reg <= CNT_ZERO;
            ce_reg <= CNT_ZERO;
            out_reg <= 1'b1;
            null_reg <= 1'b0;
            run_reg <= 1'b0;
            newc_reg <= 1'b0;
            first_reg <= 1'b0;
        end
        else if (cif.cfg_wr)
        begin
            out_reg <= (m != MODE_STOP_TC);
            run_reg <= 1'b0;
            newc_reg <= 1'b0;
            null_reg <= 1'b1;
        end
        else if (cif.load)
        begin
            cr_reg <= cif.load_val;
            newc_reg <= 1'b1;
            null_reg <= 1'b1;
            if (m == MODE_STOP_TC)
                out_reg <= 1'b0;
        end
        else if (cif.hold && m == MODE_STOP_TC)
            run_reg <= 1'b0;
        else if (tick)
        begin
            unique case (m)
                MODE_STOP_TC, MODE_SW_STROBE:
                begin
                    if (m == MODE_SW_STROBE)
                        out_reg <= 1'b1;
                    if (newc_reg)
                    begin
                        ce_reg <= cr_reg;
                        newc_reg <= 1'b0;
                        null_reg <= 1'b0;
                        run_reg <= 1'b1;
                    end
                    else if (run_reg && gate)
                    begin
                        ce_reg <= dec1;
                        if (ce_reg == CNT_ONE)
                        begin
                            out_reg <= (m == MODE_STOP_TC);
                            run_reg <= (m == MODE_STOP_TC);
                        end
                    end
                end
                MODE_ONESHOT, MODE_HW_STROBE:
                begin
                    if (m == MODE_HW_STROBE)
                        out_reg <= 1'b1;
                    if (trig)
                    begin
                        ce_reg <= cr_reg;
                        newc_reg <= 1'b0;
                        null_reg <= 1'b0;
                        run_reg <= 1'b1;
                        if (m == MODE_ONESHOT)
                            out_reg <= 1'b0;
                    end
                    else if (run_reg)
                    begin
                        ce_reg <= dec1;
                        if (ce_reg == CNT_ONE)
                        begin
                            run_reg <= 1'b0;
                            out_reg <= (m == MODE_ONESHOT);
                        end
                    end
                end
                MODE_RATE, MODE_SQUARE:
                begin
                    if (!gate)
                    begin
                        out_reg <= 1'b1;
                        run_reg <= 1'b0;
                    end
                    else if (trig || (newc_reg && !run_reg))
                    begin
                        ce_reg <= cr_reg;
                        out_reg <= 1'b1;
                        run_reg <= 1'b1;
                        newc_reg <= 1'b0;
                        null_reg <= 1'b0;
                        first_reg <= 1'b1;
                    end
                    else if (run_reg && m == MODE_RATE)
                    begin
                        ce_reg <= (ce_reg == CNT_ONE) ? cr_reg : dec1;
                        out_reg <= (ce_reg != CNT_TWO);
                        if (ce_reg == CNT_ONE)
                            null_reg <= 1'b0;
                    end
                    else if (run_reg)
                    begin
                        first_reg <= (sq_nxt == CNT_ZERO);
                        ce_reg <= (sq_nxt == CNT_ZERO) ? cr_reg : sq_nxt;
                        if (sq_nxt == CNT_ZERO)
                        begin
                            out_reg <= !out_reg;
                            null_reg <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Checks on the counting core
    property p_mode0_low;
        cif.cfg_wr && mode_norm(cif.mode) == MODE_STOP_TC |=> !out_reg;
    endproperty
    a_mode0_low: assert property (p_mode0_low) else $error("mode 0 output not low");
    property p_load_null;
        cif.load && !cif.cfg_wr |=> null_reg && cr_reg == $past(cif.load_val);
    endproperty
    a_load_null: assert property (p_load_null) else $error("load not taken");
    property p_rate_low;
        m == MODE_RATE && run_reg && gate && !out_reg && tick && !cif.cfg_wr && !cif.load
            |=> out_reg;
    endproperty
    a_rate_low: assert property (p_rate_low) else $error("rate low too long");
    property p_bcd_wrap;
        cif.bcd && m == MODE_STOP_TC && run_reg && gate && tick && !newc_reg
            && ce_reg == CNT_ZERO && !cif.cfg_wr && !cif.load && !cif.hold |=> ce_reg == BCD_TOP;
    endproperty
    a_bcd_wrap: assert property (p_bcd_wrap) else $error("bcd wrap wrong");
    property p_load_ce;
        m == MODE_STOP_TC && newc_reg && tick && !cif.cfg_wr && !cif.load && !cif.hold
            |=> ce_reg == $past(cr_reg) && !null_reg;
    endproperty
    a_load_ce: assert property (p_load_ce) else $error("count not moved in");
    property p_strobe_back;
        m == MODE_SW_STROBE && !out_reg && tick && !cif.cfg_wr && !cif.load |=> out_reg;
    endproperty
    a_strobe_back: assert property (p_strobe_back) else $error("strobe too long");
    cv_square: cover property (m == MODE_SQUARE && $fell(out_reg));
endmodule
`default_nettype wire

// ==== rtl/titp_sync.sv ====
// Two-stage pin synchroniser with rising-edge detect
`timescale 1ns/10ps
`default_nettype none
module titp_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg;
    logic [2:0] prime_reg;
    // Only the second stage reads the first
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // Edge detect armed once the third stage holds a real pin sample, so a pin idling high
    // gives no false rise after reset
    always_ff @(posedge clk)
    begin
        if (!resetn)
            prime_reg <= '0;
        else
            prime_reg <= {prime_reg[1:0], 1'b1};
    end
    assign lvl = s2_reg;
    assign rise = s2_reg & ~s3_reg & {W{prime_reg[2]}};
endmodule
`default_nettype wire

// ==== rtl/titp_timer_pacer.sv ====
// Three interval counters with word-wide host ports and a cascaded pacer
`timescale 1ns/10ps
`default_nettype none
module titp_timer_pacer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [titp_pkg::ADDR_W-1:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_wdata,
    output logic [15:0] io_rdata,
    input wire logic [titp_pkg::NUM_CNT-1:0] gate_pin,
    input wire logic counter0_ext_clk,
    input wire logic counter0_clk_internal,
    output logic [titp_pkg::NUM_CNT-1:0] counter_out,
    output logic ad_trigger
);
    import titp_pkg::*;

    logic [ACC_W-1:0] acc_reg, acc_sum;
    logic tick_reg;
    logic [NUM_CNT-1:0] gate_lvl, gate_rise, ce;
    logic ext_lvl, ext_rise;
    logic out1_q_reg, out2_q_reg, ce2_reg, ad_trig_reg;
    logic ctrl_wr;
    logic [BYTE_W-1:0] wbyte;
    logic [1:0] cw_sel, cw_af;
    logic [2:0] cw_mode;
    logic cw_bcd;
    logic [BYTE_W-1:0] rd_byte [NUM_CNT];
    logic [15:0] rdata_reg, rdata_next;

    titp_cnt_if cif [NUM_CNT] ();

    // Port decode, shared by the write and read paths
    function automatic logic port_hit(input logic [ADDR_W-1:0] a, input int idx);
        return a == OFS_CNT[idx];
    endfunction

    // Pins from outside the clock domain
    titp_sync #(
        .W(NUM_CNT + 1)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .din({counter0_ext_clk, gate_pin}),
        .lvl({ext_lvl, gate_lvl}),
        .rise({ext_rise, gate_rise})
    );

    // Fractional divider: average 10 MHz count tick from the 25 MHz clock
    assign acc_sum = acc_reg + ACC_STEP;
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            acc_reg <= '0;
            tick_reg <= 1'b0;
        end
        else if (acc_sum >= ACC_WRAP)
        begin
            acc_reg <= acc_sum - ACC_WRAP;
            tick_reg <= 1'b1;
        end
        else
        begin
            acc_reg <= acc_sum;
            tick_reg <= 1'b0;
        end
    end

    // Counter 2 steps on each rising edge of counter 1 output
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            out1_q_reg <= 1'b1;
            out2_q_reg <= 1'b1;
            ce2_reg <= 1'b0;
            ad_trig_reg <= 1'b0;
        end
        else
        begin
            out1_q_reg <= cif[1].out;
            out2_q_reg <= cif[2].out;
            ce2_reg <= cif[1].out & ~out1_q_reg;
            ad_trig_reg <= cif[2].out & ~out2_q_reg;
        end
    end

    // Count clock per channel
    assign ce[0] = counter0_clk_internal ? tick_reg : ext_rise;
    assign ce[1] = tick_reg;
    assign ce[2] = ce2_reg;

    // Control word fields
    assign ctrl_wr = io_wr && (io_addr == OFS_CTRL);
    assign wbyte = io_wdata[BYTE_W-1:0];
    assign cw_sel = wbyte[SEL_LO+:2];
    assign cw_af = wbyte[AF_LO+:2];
    assign cw_mode = wbyte[MODE_LO+:3];
    assign cw_bcd = wbyte[BCD_BIT];

    for (genvar i = 0; i < NUM_CNT; i++)
    begin : g_ch
        logic [2:0] mode_reg;
        logic bcd_reg;
        logic [1:0] af_reg;
        logic [BYTE_W-1:0] lsb_reg, st_reg;
        logic [CNT_W-1:0] ol_reg, rd_word;
        logic wr_hi_reg, rd_hi_reg, ol_v_reg, st_v_reg;
        logic cw_hit, cfg_hit, rb_hit, wr_hit, rd_hit, latch_cmd, sta_cmd, rel;

        // Per-channel strobes
        assign cw_hit = ctrl_wr && cw_sel == 2'(i);
        assign cfg_hit = cw_hit && cw_af != AF_LATCH;
        assign rb_hit = ctrl_wr && cw_sel == SEL_READBACK && wbyte[RB_C0+i];
        assign wr_hit = io_wr && port_hit(io_addr, i);
        assign rd_hit = io_rd && port_hit(io_addr, i);
        assign latch_cmd = (cw_hit && cw_af == AF_LATCH) || (rb_hit && !wbyte[RB_CNT_N]);
        assign sta_cmd = rb_hit && !wbyte[RB_STA_N];
        assign rel = af_reg != AF_BOTH || rd_hi_reg;

        // Channel configuration
        always_ff @(posedge clk)
        begin
            if (!resetn)
            begin
                mode_reg <= MODE_STOP_TC;
                bcd_reg <= 1'b0;
                af_reg <= AF_BOTH;
            end
            else if (cfg_hit)
            begin
                mode_reg <= cw_mode;
                bcd_reg <= cw_bcd;
                af_reg <= cw_af;
            end
        end

        // Write byte sequencing
        always_ff @(posedge clk)
        begin
            if (!resetn)
            begin
                wr_hi_reg <= 1'b0;
                lsb_reg <= BYTE_ZERO;
            end
            else if (cfg_hit)
                wr_hi_reg <= 1'b0;
            else if (wr_hit && af_reg == AF_BOTH)
            begin
                wr_hi_reg <= !wr_hi_reg;
                if (!wr_hi_reg)
                    lsb_reg <= wbyte;
            end
        end

        assign cif[i].cfg_wr = cfg_hit;
        // New mode reaches the core in the write cycle, so the output level follows it
        assign cif[i].mode = cfg_hit ? cw_mode : mode_reg;
        assign cif[i].bcd = bcd_reg;
        assign cif[i].load = wr_hit && (af_reg != AF_BOTH || wr_hi_reg);
        assign cif[i].hold = wr_hit && af_reg == AF_BOTH && !wr_hi_reg;
        assign cif[i].load_val = (af_reg == AF_LSB) ? {BYTE_ZERO, wbyte} :
            (af_reg == AF_MSB) ? {wbyte, BYTE_ZERO} : {wbyte, lsb_reg};

        // Count latch, held until fully read
        always_ff @(posedge clk)
        begin
            if (!resetn)
            begin
                ol_v_reg <= 1'b0;
                ol_reg <= CNT_ZERO;
            end
            else if (cfg_hit)
                ol_v_reg <= 1'b0;
            else if (latch_cmd && !ol_v_reg)
            begin
                ol_v_reg <= 1'b1;
                ol_reg <= cif[i].cnt;
            end
            else if (rd_hit && !st_v_reg && rel)
                ol_v_reg <= 1'b0;
        end

        // Status latch, read before any count byte
        always_ff @(posedge clk)
        begin
            if (!resetn)
            begin
                st_v_reg <= 1'b0;
                st_reg <= BYTE_ZERO;
            end
            else if (cfg_hit)
                st_v_reg <= 1'b0;
            else if (sta_cmd && !st_v_reg)
            begin
                st_v_reg <= 1'b1;
                st_reg <= {cif[i].out, cif[i].null_cnt, af_reg, mode_reg, bcd_reg};
            end
            else if (rd_hit)
                st_v_reg <= 1'b0;
        end

        // Read byte order for low-then-high format
        always_ff @(posedge clk)
        begin
            if (!resetn)
                rd_hi_reg <= 1'b0;
            else if (cfg_hit)
                rd_hi_reg <= 1'b0;
            else if (rd_hit && !st_v_reg && af_reg == AF_BOTH)
                rd_hi_reg <= !rd_hi_reg;
        end

        // Byte presented on a read of this port
        assign rd_word = ol_v_reg ? ol_reg : cif[i].cnt;
        assign rd_byte[i] = st_v_reg ? st_reg :
            (af_reg == AF_MSB || (af_reg == AF_BOTH && rd_hi_reg)) ?
            rd_word[CNT_W-1:BYTE_W] : rd_word[BYTE_W-1:0];

        // Channel core
        titp_counter u_cnt (
            .clk(clk),
            .resetn(resetn),
            .tick(ce[i]),
            .gate(gate_lvl[i]),
            .gate_rise(gate_rise[i]),
            .cif(cif[i])
        );
        assign counter_out[i] = cif[i].out;
    end

    // Read data; control port and unmapped addresses read zero
    always_comb
    begin
        rdata_next = '0;
        for (int k = 0; k < NUM_CNT; k++)
        begin
            if (port_hit(io_addr, k))
                rdata_next = {BYTE_ZERO, rd_byte[k]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            rdata_reg <= '0;
        else if (io_rd)
            rdata_reg <= rdata_next;
    end

    assign io_rdata = rdata_reg;
    assign ad_trigger = ad_trig_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // Checks on the register side and the pacer chain
    property p_ad_trig;
        $rose(cif[2].out) |=> ad_trigger ##1 !ad_trigger;
    endproperty
    a_ad_trig: assert property (p_ad_trig) else $error("pacer trigger missing");

    property p_cascade;
        $rose(cif[1].out) |=> ce[2] ##1 !ce[2];
    endproperty
    a_cascade: assert property (p_cascade) else $error("cascade step missing");

    property p_tick_gap;
        tick_reg |=> !tick_reg ##1 (!tick_reg || !$past(tick_reg, 4)) ##[0:1] tick_reg;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick rate wrong");

    property p_src;
        !counter0_clk_internal && !ext_rise |-> !ce[0];
    endproperty
    a_src: assert property (p_src) else $error("counter 0 source wrong");

    property p_ctrl_fields;
        ctrl_wr && cw_sel == 2'h1 && cw_af != AF_LATCH
            |=> g_ch[1].mode_reg == $past(io_wdata[3:1]) && g_ch[1].af_reg == $past(cw_af);
    endproperty
    a_ctrl_fields: assert property (p_ctrl_fields) else $error("control decode wrong");

    property p_rb_no_cfg;
        ctrl_wr && cw_sel == SEL_READBACK |=> $stable(g_ch[0].mode_reg) && $stable(g_ch[2].af_reg);
    endproperty
    a_rb_no_cfg: assert property (p_rb_no_cfg) else $error("read-back altered mode");

    property p_rb_latch;
        ctrl_wr && cw_sel == SEL_READBACK && wbyte[2] && !wbyte[RB_CNT_N] && !g_ch[1].ol_v_reg
            |=> g_ch[1].ol_v_reg && g_ch[1].ol_reg == $past(cif[1].cnt);
    endproperty
    a_rb_latch: assert property (p_rb_latch) else $error("read-back count not latched");

    property p_latch_cmd;
        ctrl_wr && cw_sel == 2'h0 && cw_af == AF_LATCH && !g_ch[0].ol_v_reg
            |=> g_ch[0].ol_v_reg ##1 (g_ch[0].ol_v_reg || $past(io_rd));
    endproperty
    a_latch_cmd: assert property (p_latch_cmd) else $error("count latch lost");

    property p_ctrl_rd;
        io_rd && io_addr == OFS_CTRL |=> io_rdata == 16'h0000;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control port readable");

    cv_trig: cover property (ad_trigger);
    cv_status: cover property (g_ch[0].st_v_reg && io_rd && io_addr == OFS_CNT[0]);
    cv_pair: cover property (g_ch[2].wr_hi_reg && cif[2].load);
endmodule
`default_nettype wire

// ==== verification/titp_host.sv ====
// Host bus model issuing word-wide port accesses
`timescale 1ns/10ps
`default_nettype none
module titp_host (
    input wire logic clk,
    output logic [4:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [15:0] io_wdata,
    input wire logic [15:0] io_rdata
);
    // Idle bus from time zero
    initial {io_addr, io_wr, io_rd, io_wdata} = '0;
    // One word access held over one rising edge; read answer taken at the falling edge that ends it
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] v,
        output logic [15:0] q);
        @(negedge clk);
        io_addr = a;
        io_wdata = v;
        io_wr = w;
        io_rd = !w;
        @(negedge clk);
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = ~v;
        q = io_rdata;
    endtask
endmodule
`default_nettype wire

// ==== verification/titp_timer_pacer_tb.sv ====
// Self-checking bench for the triple interval timer pacer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module titp_timer_pacer_tb;
    import titp_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, io_wr, io_rd, ad_trigger;
    logic [4:0] io_addr;
    logic [15:0] io_wdata, io_rdata, d;
    logic [7:0] c;
    logic [2:0] gate_pin = 3'b111, counter_out;
    logic ext_clk = 1'b0, clk_int = 1'b1;
    logic [31:0] seed = 32'hf646;
    int failures = 0, checks = 0, cyc = 0, trig = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    titp_host host_u (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata));
    titp_timer_pacer dut_u (.clk(clk), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .gate_pin(gate_pin),
        .counter0_ext_clk(ext_clk), .counter0_clk_internal(clk_int),
        .counter_out(counter_out), .ad_trigger(ad_trigger));
    // Xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Status of a freshly programmed counter
    function automatic logic [15:0] st(input logic o, input logic [7:0] cw);
        return {8'h00, o, 1'b1, cw[5:0]};
    endfunction
    // Counts, verdict, stop
    task automatic give_verdict(input int late);
        failures += late;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Cycle ceiling against a hang
    always @(posedge clk)
        if (++cyc > 20000)
            give_verdict(1);
    // Counter 0 in mode 0: status, then time to output rise at 2 ticks per 5 clocks
    task automatic run0(input logic [7:0] cw, input logic [15:0] v, input int n);
        int t;
        host_u.acc(1'b1, OFS_CTRL, {8'h00, cw}, d);
        host_u.acc(1'b1, OFS_CTRL, 16'h00e2, d);
        host_u.acc(1'b0, OFS_CNT[0], 16'h0000, d);
        `CHK(d, st(1'b0, cw))
        host_u.acc(1'b1, OFS_CNT[0], {8'h00, v[7:0]}, d);
        host_u.acc(1'b1, OFS_CNT[0], {8'h00, v[15:8]}, d);
        for (t = 0; counter_out[0] !== 1'b1 && t < 3 * n + 12; t++) @(negedge clk);
        `CHK(2 * t >= 5 * n + 1 && 2 * t <= 5 * n + 9, 1'b1)
    endtask
    // External event pulses on counter 0, slow enough for the synchroniser
    task automatic ext_pulse(input int n);
        repeat (n)
        begin
            @(negedge clk);
            ext_clk = 1'b1;
            repeat (3) @(negedge clk);
            ext_clk = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask
    // Reset, map, counting, every mode, then the pacer
    initial
    begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        `CHK({io_rdata, ad_trigger, counter_out}, 20'h00007)
        host_u.acc(1'b0, 5'h00, 16'h0000, d);
        `CHK(d, 16'h0000)
        host_u.acc(1'b0, OFS_CTRL, 16'h0000, d);
        `CHK(d, 16'h0000)
        seed = xs(seed);
        run0(8'h30, {8'h00, seed[7:0] | 8'h10}, int'(seed[7:0] | 8'h10));
        run0(8'h31, 16'h0010, 10);
        // Counter 0 on external events: latch held over a step, gate low holds the count
        clk_int = 1'b0;
        host_u.acc(1'b1, OFS_CTRL, 16'h0010, d);
        host_u.acc(1'b1, OFS_CNT[0], 16'h0005, d);
        ext_pulse(3);
        host_u.acc(1'b1, OFS_CTRL, 16'h0000, d);
        ext_pulse(1);
        gate_pin[0] = 1'b0;
        ext_pulse(2);
        host_u.acc(1'b0, OFS_CNT[0], 16'h0000, d);
        `CHK(d, 16'h0003)
        host_u.acc(1'b0, OFS_CNT[0], 16'h0000, d);
        `CHK(d, 16'h0002)
        gate_pin[0] = 1'b1;
        clk_int = 1'b1;
        for (int m = 0; m < 8; m++)
        begin
            seed = xs(seed);
            c = {4'h5, 3'(m), seed[0]};
            host_u.acc(1'b1, OFS_CTRL, {8'h00, c}, d);
            host_u.acc(1'b1, OFS_CTRL, 16'h00c4, d);
            host_u.acc(1'b0, OFS_CNT[1], 16'h0000, d);
            `CHK(d, st(m != 0, c))
        end
        // Counter 1 as a software strobe: one low tick of 2 or 3 clocks, then it stops
        host_u.acc(1'b1, OFS_CTRL, 16'h0058, d);
        host_u.acc(1'b1, OFS_CNT[1], 16'h0003, d);
        repeat (40) @(negedge clk) trig += !counter_out[1];
        `CHK(trig >= 2 && trig <= 3, 1'b1)
        trig = 0;
        host_u.acc(1'b1, OFS_CTRL, 16'h0054, d);
        host_u.acc(1'b1, OFS_CNT[1], 16'h0003, d);
        host_u.acc(1'b1, OFS_CTRL, 16'h0094, d);
        host_u.acc(1'b1, OFS_CNT[2], 16'h0002, d);
        repeat (300) @(negedge clk) trig += ad_trigger;
        `CHK(trig >= 16 && trig <= 21, 1'b1)
        give_verdict(0);
    end
endmodule
`default_nettype wire
